/* pwo_pkg.sv */
// Package of constants for the power output control block
//
// Functional notes
// - Sense gain select 1 picks 0.5 A range, 0 picks 2.5 A; reset clears.
// - Limit codes 0-2 mean no limit; 3-7 select 55 to 740 mA.
// - Lamp conducts only with power stage enable and lamp switch on set.
// - Low or high voltage flag set forces the lamp output off.
// - Write 1 clears voltage flags; flag re-sets while condition persists.
// - Prewarning flag raised; enabled temperature limit resets and kills outputs.
// - Lamp overcurrent switches lamp off and sets lamp overcurrent flag.
// - Each chop input rising edge re-arms the lamp after overcurrent.
// - Writing 1 to the lamp overcurrent flag clears it.
// - Supply output needs enable and supply on; voltage flags ignored.
// - Supply overtemperature shutdown acts only with temperature reset enabled.
// - Supply overcurrent switches supply off and sets its status flag.
// - Power stage enable, control bit 7, gates all power stages.
// - Slew select: 00 20k, 01 10k, 10 high speed 8x, 11 4x.
// - Write 1 to stop bit 0 requests STOP; reset or IRQ clears.
// - Status bits 7..0: hall, LIN limit, supply, lamp, LV, HV, bridge, temp.
// - Status low voltage bit mirrors the interrupt flag register bit.
// - Status overtemperature bit mirrors the interrupt flag register bit.
package pwo_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_BRIDGE_CTRL   = 8'h02;
  localparam logic [7:0] IDX_SYSTEM_CTRL   = 8'h03;
  localparam logic [7:0] IDX_POWER_OUT     = 8'h04;
  localparam logic [7:0] IDX_IRQ_FLAGS     = 8'h05;
  localparam logic [7:0] IDX_SYSTEM_STATUS = 8'h0C;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BC_SENSE_GAIN  = 6;
  localparam int SC_POWER_STAGE = 7;
  localparam int SC_SLEW_HI     = 6;
  localparam int SC_SLEW_LO     = 5;
  localparam int SC_STOP        = 0;
  localparam int PO_LAMP_ON     = 0;
  localparam int PO_SUPPLY_ON   = 1;
  localparam int IF_HT_RESET_EN = 7;
  localparam int IF_HTF         = 2;
  localparam int IF_HVF         = 1;
  localparam int IF_LVF         = 0;
  localparam int SS_HALL_OC     = 7;
  localparam int SS_LIN_CL      = 6;
  localparam int SS_SUPPLY_OC   = 5;
  localparam int SS_LAMP_OC     = 4;
  localparam int SS_LVF         = 3;
  localparam int SS_HVF         = 2;
  localparam int SS_BRIDGE_OC   = 1;
  localparam int SS_HTF         = 0;

  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [7:0] RST_REG        = 8'h00;
  localparam logic [2:0] LIMIT_FIRST_ON = 3'h3;
  localparam logic [1:0] SLEW_INITIAL   = 2'h0;
  localparam logic [1:0] SLEW_SLOW      = 2'h1;
  localparam logic [1:0] SLEW_HS_8X     = 2'h2;
  localparam logic [1:0] SLEW_HS_4X     = 2'h3;

  // Synchronised detector inputs, one bit each
  localparam int N_DET     = 11;
  localparam int D_LV      = 0;
  localparam int D_HV      = 1;
  localparam int D_OT_WARN = 2;
  localparam int D_OT_LIM  = 3;
  localparam int D_LAMP_OC = 4;
  localparam int D_SUP_OC  = 5;
  localparam int D_BRG_OC  = 6;
  localparam int D_HALL_OC = 7;
  localparam int D_LIN_CL  = 8;
  localparam int D_CHOP    = 9;
  localparam int D_CPU_IRQ = 10;

endpackage

/* pwo_input_sync.sv */
// Three-stage pin synchroniser with agreement filter and rise detect
`timescale 1ns/10ps
module pwo_input_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // Asynchronous pins
  input  wire logic [WIDTH-1:0] pinIn,
  // Clean levels and rise pulses
  output logic      [WIDTH-1:0] levelOut,
  output logic      [WIDTH-1:0] riseOut
);

  logic [WIDTH-1:0] st1_q;
  logic [WIDTH-1:0] st2_q;
  logic [WIDTH-1:0] st3_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // Stage one feeds stage two only; filter looks at two and three
      always_ff @(posedge core_clk) begin
        if (rst) begin
          st1_q[i]    <= 1'b0;
          st2_q[i]    <= 1'b0;
          st3_q[i]    <= 1'b0;
          levelOut[i] <= 1'b0;
          riseOut[i]  <= 1'b0;
        end else begin
          st1_q[i] <= pinIn[i];
          st2_q[i] <= st1_q[i];
          st3_q[i] <= st2_q[i];
          if (st2_q[i] == st3_q[i]) begin
            levelOut[i] <= st3_q[i];
          end
          riseOut[i] <= (st2_q[i] == st3_q[i]) && st3_q[i]
                        && !levelOut[i];
        end
      end
    end
  endgenerate

endmodule // pwo_input_sync

/* pwo_sticky_flag.sv */
// Sticky event flag, write-one-to-clear, set beats clear
`timescale 1ns/10ps
module pwo_sticky_flag (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Event and clear
  input  wire logic setIn,
  input  wire logic clearIn,
  // Flag
  output logic      flagOut
);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      flagOut <= 1'b0;
    end else if (setIn) begin
      flagOut <= 1'b1;
    end else if (clearIn) begin
      flagOut <= 1'b0;
    end
  end

endmodule // pwo_sticky_flag

/* pwo_power_output_control.sv */
// Power output control: registers, protection and output gating
`timescale 1ns/10ps
module pwo_power_output_control (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // APB slave
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  // Analog detector pins
  input  wire logic       lowVoltageDet,
  input  wire logic       highVoltageDet,
  input  wire logic       overTempWarnDet,
  input  wire logic       overTempLimitDet,
  input  wire logic       lampOcDet,
  input  wire logic       supplyOcDet,
  input  wire logic       bridgeOcDet,
  input  wire logic       hallOcDet,
  input  wire logic       linCurrentLimitDet,
  // Chop frequency pin and CPU interrupt request
  input  wire logic       chopFrequencyInput,
  input  wire logic       cpuIrqReq,
  // Power stage controls
  output logic            powerStageEnable,
  output logic            lampOutput,
  output logic            switchedSupplyOutput,
  output logic            senseGainSelect,
  output logic [2:0]      limitSelect,
  output logic            limitActive,
  output logic [1:0]      slewSelect,
  output logic            stopRequest,
  output logic            systemResetReq
);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  logic [pwo_pkg::N_DET-1:0] detPins;
  logic [pwo_pkg::N_DET-1:0] det;
  logic [pwo_pkg::N_DET-1:0] detRise;

  assign detPins = {cpuIrqReq, chopFrequencyInput, linCurrentLimitDet,
                    hallOcDet, bridgeOcDet, supplyOcDet, lampOcDet,
                    overTempLimitDet, overTempWarnDet, highVoltageDet,
                    lowVoltageDet};

  pwo_input_sync #(
    .WIDTH (pwo_pkg::N_DET)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pinIn    (detPins),
    .levelOut (det),
    .riseOut  (detRise)
  );

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic [7:0] regIdx;
  logic       alignedOk;
  logic       hitBridge;
  logic       hitSysCtl;
  logic       hitPowerOut;
  logic       hitIrqFlags;
  logic       hitSysStat;
  logic       hitAny;
  logic       setupPhase;
  logic       accessDone;
  logic       wrDone;
  logic [7:0] wByte;

  assign regIdx      = {2'h0, paddr[7:2]};
  assign alignedOk   = (paddr[1:0] == 2'h0);
  assign hitBridge   = alignedOk && (regIdx == pwo_pkg::IDX_BRIDGE_CTRL);
  assign hitSysCtl   = alignedOk && (regIdx == pwo_pkg::IDX_SYSTEM_CTRL);
  assign hitPowerOut = alignedOk && (regIdx == pwo_pkg::IDX_POWER_OUT);
  assign hitIrqFlags = alignedOk && (regIdx == pwo_pkg::IDX_IRQ_FLAGS);
  assign hitSysStat  = alignedOk && (regIdx == pwo_pkg::IDX_SYSTEM_STATUS);
  assign hitAny      = hitBridge | hitSysCtl | hitPowerOut | hitIrqFlags
                       | hitSysStat;
  assign setupPhase  = psel && !penable && !pready;
  // Writes land only at the completing access edge
  assign accessDone  = psel && penable && pready;
  assign wrDone      = accessDone && pwrite && hitAny;
  assign wByte       = pwdata[7:0];

  logic wrBridge;
  logic wrSysCtl;
  logic wrPowerOut;
  logic wrIrqFlags;
  logic wrSysStat;

  assign wrBridge   = wrDone && hitBridge;
  assign wrSysCtl   = wrDone && hitSysCtl;
  assign wrPowerOut = wrDone && hitPowerOut;
  assign wrIrqFlags = wrDone && hitIrqFlags;
  assign wrSysStat  = wrDone && hitSysStat;

  // ****************************************************************
  // Software control registers
  // ****************************************************************
  logic [7:0] bridgeCtrl_q;
  logic [7:0] bridgeCtrl_d;
  logic [7:0] system_control_q;
  logic [7:0] system_control_d;
  logic [7:0] powerOut_q;
  logic [7:0] powerOut_d;
  logic       htResetEn_q;
  logic       stop_q;

  // Only defined fields are stored; the rest reads as zero
  assign bridgeCtrl_d = {1'b0, wByte[pwo_pkg::BC_SENSE_GAIN],
                         3'h0, wByte[2:0]};
  assign system_control_d     = {wByte[pwo_pkg::SC_POWER_STAGE],
                         wByte[pwo_pkg::SC_SLEW_HI],
                         wByte[pwo_pkg::SC_SLEW_LO], 5'h00};
  assign powerOut_d   = {6'h00, wByte[pwo_pkg::PO_SUPPLY_ON],
                         wByte[pwo_pkg::PO_LAMP_ON]};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bridgeCtrl_q <= pwo_pkg::RST_REG;
      system_control_q     <= pwo_pkg::RST_REG;
      powerOut_q   <= pwo_pkg::RST_REG;
      htResetEn_q  <= 1'b0;
    end else begin
      if (wrBridge) begin
        bridgeCtrl_q <= bridgeCtrl_d;
      end
      if (wrSysCtl) begin
        system_control_q <= system_control_d;
      end
      if (wrPowerOut) begin
        powerOut_q <= powerOut_d;
      end
      if (wrIrqFlags) begin
        htResetEn_q <= wByte[pwo_pkg::IF_HT_RESET_EN];
      end
    end
  end

  // Stop bit is write-only; a CPU interrupt cancels it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stop_q <= 1'b0;
    end else if (wrSysCtl && wByte[pwo_pkg::SC_STOP]) begin
      stop_q <= 1'b1;
    end else if (det[pwo_pkg::D_CPU_IRQ]) begin
      stop_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Sticky flags
  // ****************************************************************
  // Order: LV, HV, temp warn, lamp oc, supply oc, bridge oc, hall oc
  localparam int N_FLAG = 7;
  logic [N_FLAG-1:0] flagSet;
  logic [N_FLAG-1:0] flagClr;
  logic [N_FLAG-1:0] flag;

  // Levels re-set the flag each cycle, so clears do not stick
  assign flagSet = {det[pwo_pkg::D_HALL_OC], det[pwo_pkg::D_BRG_OC],
                    det[pwo_pkg::D_SUP_OC], det[pwo_pkg::D_LAMP_OC],
                    det[pwo_pkg::D_OT_WARN], det[pwo_pkg::D_HV],
                    det[pwo_pkg::D_LV]};
  assign flagClr = {
    wrSysStat && wByte[pwo_pkg::SS_HALL_OC],
    wrSysStat && wByte[pwo_pkg::SS_BRIDGE_OC],
    wrSysStat && wByte[pwo_pkg::SS_SUPPLY_OC],
    wrSysStat && wByte[pwo_pkg::SS_LAMP_OC],
    wrIrqFlags && wByte[pwo_pkg::IF_HTF],
    wrIrqFlags && wByte[pwo_pkg::IF_HVF],
    wrIrqFlags && wByte[pwo_pkg::IF_LVF]
  };

  genvar f;
  generate
    for (f = 0; f < N_FLAG; f++) begin : g_flag
      pwo_sticky_flag u_flag (
        .core_clk (core_clk),
        .rst      (rst),
        .setIn    (flagSet[f]),
        .clearIn  (flagClr[f]),
        .flagOut  (flag[f])
      );
    end
  endgenerate

  logic lvFlag;
  logic hvFlag;
  logic htFlag;
  logic lampOcFlag;
  logic supplyOcFlag;
  logic bridgeOcFlag;
  logic hallOcFlag;

  assign lvFlag       = flag[0];
  assign hvFlag       = flag[1];
  assign htFlag       = flag[2];
  assign lampOcFlag   = flag[3];
  assign supplyOcFlag = flag[4];
  assign bridgeOcFlag = flag[5];
  assign hallOcFlag   = flag[6];

  // ****************************************************************
  // Protection and output decodes
  // ****************************************************************
  // Decodes stay out of the clocked blocks, which only store
  logic       thermHit;
  logic       lampOcNow;
  logic       chopRearm;
  logic       lampFlagClr;
  logic       supplyOcNow;
  logic       gainCode;
  logic [2:0] limitCode;
  logic       limitOn;
  logic [1:0] slewCode;

  assign thermHit    = htResetEn_q && det[pwo_pkg::D_OT_LIM];
  assign lampOcNow   = det[pwo_pkg::D_LAMP_OC];
  assign chopRearm   = detRise[pwo_pkg::D_CHOP];
  assign lampFlagClr = flagClr[3];
  assign supplyOcNow = det[pwo_pkg::D_SUP_OC];
  assign gainCode    = bridgeCtrl_q[pwo_pkg::BC_SENSE_GAIN];
  assign limitCode   = bridgeCtrl_q[2:0];
  // Codes below the first limit step mean no current limit
  assign limitOn     = (limitCode >= pwo_pkg::LIMIT_FIRST_ON);
  assign slewCode    = system_control_q[pwo_pkg::SC_SLEW_HI:
                                pwo_pkg::SC_SLEW_LO];

  // ****************************************************************
  // Thermal trip
  // ****************************************************************
  // Held until reset: the system reset request is this trip, registered one cycle later
  logic thermTrip_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      thermTrip_q <= 1'b0;
    end else if (thermHit) begin
      thermTrip_q <= 1'b1;
    end
  end

  // ****************************************************************
  // Lamp overcurrent latch with chop re-arm
  // ****************************************************************
  // Driver re-arms on chop edges, flag stays for software to judge
  logic lampOff_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lampOff_q <= 1'b0;
    end else if (lampOcNow) begin
      lampOff_q <= 1'b1;
    end else if (chopRearm) begin
      lampOff_q <= 1'b0;
    end else if (lampFlagClr) begin
      lampOff_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Output gating
  // ****************************************************************
  logic stageOn;
  logic lampOn;
  logic supplyOn;

  assign stageOn  = system_control_q[pwo_pkg::SC_POWER_STAGE] && !thermTrip_q;
  assign lampOn   = stageOn && powerOut_q[pwo_pkg::PO_LAMP_ON]
                    && !lvFlag && !hvFlag
                    && !lampOff_q && !lampOcNow;
  // Voltage flags deliberately left out of the supply path
  assign supplyOn = stageOn && powerOut_q[pwo_pkg::PO_SUPPLY_ON]
                    && !supplyOcFlag
                    && !supplyOcNow;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      powerStageEnable     <= 1'b0;
      lampOutput           <= 1'b0;
      switchedSupplyOutput <= 1'b0;
      senseGainSelect      <= 1'b0;
      limitSelect          <= 3'h0;
      limitActive          <= 1'b0;
      slewSelect           <= pwo_pkg::SLEW_INITIAL;
      stopRequest          <= 1'b0;
      systemResetReq       <= 1'b0;
    end else begin
      powerStageEnable     <= stageOn;
      lampOutput           <= lampOn;
      switchedSupplyOutput <= supplyOn;
      senseGainSelect      <= gainCode;
      limitSelect          <= limitCode;
      limitActive          <= limitOn;
      slewSelect           <= slewCode;
      stopRequest          <= stop_q;
      systemResetReq       <= thermTrip_q;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [7:0] sysStatRd;
  logic [7:0] irqFlagsRd;
  logic [7:0] rdByte;

  assign sysStatRd  = {hallOcFlag, det[pwo_pkg::D_LIN_CL], supplyOcFlag,
                       lampOcFlag, lvFlag, hvFlag, bridgeOcFlag,
                       htFlag};
  assign irqFlagsRd = {htResetEn_q, 4'h0, htFlag, hvFlag, lvFlag};
  assign rdByte     = hitBridge   ? bridgeCtrl_q :
                      hitSysCtl   ? system_control_q     :
                      hitPowerOut ? powerOut_q   :
                      hitIrqFlags ? irqFlagsRd   :
                      hitSysStat  ? sysStatRd    : 8'h00;

  // One wait-free access phase: answer prepared during setup
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdByte};
      pslverr <= !hitAny;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // pwo_power_output_control

/* pwo_power_output_control_asserts.sv */
// Assertions on the ports of the power output control block
`timescale 1ns/10ps
module pwo_checker (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins and outputs
  input wire logic        lowVoltageDet,
  input wire logic        powerStageEnable,
  input wire logic        lampOutput,
  input wire logic        switchedSupplyOutput,
  input wire logic [2:0]  limitSelect,
  input wire logic        limitActive,
  input wire logic        systemResetReq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_setup;
    psel && !penable && !pready;
  endsequence
  // Pin must first cross the synchroniser
  sequence s_lvHeld;
    lowVoltageDet [*8];
  endsequence

  property p_answer;
    s_setup |=> pready;
  endproperty
  property p_oneCycle;
    pready |=> !pready;
  endproperty
  property p_errWithReady;
    pslverr |-> pready;
  endproperty
  property p_upperZero;
    pready |-> prdata[31:8] == 24'h0;
  endproperty
  // Enable and lamp may settle on the same edge
  property p_lampGate;
    lampOutput |-> powerStageEnable || $past(powerStageEnable);
  endproperty
  property p_supplyGate;
    switchedSupplyOutput |-> powerStageEnable || $past(powerStageEnable);
  endproperty
  property p_limit;
    limitActive == (limitSelect >= 3'h3);
  endproperty
  property p_trip;
    systemResetReq |=> systemResetReq && !powerStageEnable && !lampOutput
      && !switchedSupplyOutput;
  endproperty
  property p_lvOff;
    s_lvHeld |-> !lampOutput;
  endproperty

  a_answer: assert property (p_answer)
    else $error("no ready after setup");
  a_oneCycle: assert property (p_oneCycle)
    else $error("ready longer than one cycle");
  a_errWithReady: assert property (p_errWithReady)
    else $error("error without ready");
  a_upperZero: assert property (p_upperZero)
    else $error("upper read bits not zero");
  a_lampGate: assert property (p_lampGate)
    else $error("lamp on without enable");
  a_supplyGate: assert property (p_supplyGate)
    else $error("supply on without enable");
  a_limit: assert property (p_limit)
    else $error("limit active wrong");
  a_trip: assert property (p_trip)
    else $error("thermal trip not held");
  a_lvOff: assert property (p_lvOff)
    else $error("lamp on in low voltage");
endmodule // pwo_checker

bind pwo_power_output_control pwo_checker u_chk (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .lowVoltageDet(lowVoltageDet), .powerStageEnable(powerStageEnable),
  .lampOutput(lampOutput), .switchedSupplyOutput(switchedSupplyOutput),
  .limitSelect(limitSelect), .limitActive(limitActive),
  .systemResetReq(systemResetReq));

/* tb_top.sv */
// Self-checking bench for the power output control block
`timescale 1ns/10ps
module tb_top;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        errSeen, lowVoltageDet, highVoltageDet, overTempWarnDet;
  logic        overTempLimitDet, lampOcDet, supplyOcDet, bridgeOcDet;
  logic        hallOcDet, linCurrentLimitDet, chopFrequencyInput, cpuIrqReq;
  logic        powerStageEnable, lampOutput, switchedSupplyOutput;
  logic        senseGainSelect, limitActive, stopRequest, systemResetReq;
  logic [2:0]  limitSelect;
  logic [1:0]  slewSelect;
  int          n_errors, checked, cycles;
  localparam logic [7:0] A_BRG = {pwo_pkg::IDX_BRIDGE_CTRL[5:0], 2'b00};
  localparam logic [7:0] A_SYS = {pwo_pkg::IDX_SYSTEM_CTRL[5:0], 2'b00};
  localparam logic [7:0] A_OUT = {pwo_pkg::IDX_POWER_OUT[5:0], 2'b00};
  localparam logic [7:0] A_IRQ = {pwo_pkg::IDX_IRQ_FLAGS[5:0], 2'b00};
  localparam logic [7:0] A_STAT = {pwo_pkg::IDX_SYSTEM_STATUS[5:0], 2'b00};
  localparam logic [7:0] REG_ADDR [5] = '{A_BRG, A_SYS, A_OUT, A_IRQ, A_STAT};

  pwo_power_output_control u_dut (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lowVoltageDet(lowVoltageDet),
    .highVoltageDet(highVoltageDet), .overTempWarnDet(overTempWarnDet),
    .overTempLimitDet(overTempLimitDet), .lampOcDet(lampOcDet),
    .supplyOcDet(supplyOcDet), .bridgeOcDet(bridgeOcDet),
    .hallOcDet(hallOcDet), .linCurrentLimitDet(linCurrentLimitDet),
    .chopFrequencyInput(chopFrequencyInput), .cpuIrqReq(cpuIrqReq),
    .powerStageEnable(powerStageEnable), .lampOutput(lampOutput),
    .switchedSupplyOutput(switchedSupplyOutput),
    .senseGainSelect(senseGainSelect), .limitSelect(limitSelect),
    .limitActive(limitActive), .slewSelect(slewSelect),
    .stopRequest(stopRequest), .systemResetReq(systemResetReq));

  // ********************************
  // Clock, timeout and helpers
  // ********************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // Holds the request until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for ready
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdat    = prdata;
    errSeen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, rdat, {24'h0, e});
    chk("slave error", 32'(errSeen), 32'h0);
  endtask

  task automatic doReset();
    rst <= 1'b1;
    wt(20);
    rst <= 1'b0;
  endtask

  task automatic rstCheck();
    chk("outputs", 32'({powerStageEnable, lampOutput, switchedSupplyOutput,
      senseGainSelect, limitSelect, limitActive, slewSelect, stopRequest,
      systemResetReq}), 32'h0);
    foreach (REG_ADDR[i]) rd(REG_ADDR[i], 8'h00, "reset value");
  endtask

  // ********************************
  // Test sequence
  // ********************************
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {lowVoltageDet, highVoltageDet, overTempWarnDet, overTempLimitDet} = '0;
    {lampOcDet, supplyOcDet, bridgeOcDet, hallOcDet} = '0;
    {linCurrentLimitDet, chopFrequencyInput, cpuIrqReq} = '0;
    {n_errors, checked, cycles} = '0;
    doReset();
    rstCheck();
    for (int i = 0; i < 16; i++) begin
      wr(A_BRG, {1'b0, i[3], 3'h0, i[2:0]});
      wt(2);
      chk("gain", 32'(senseGainSelect), 32'(i[3]));
      chk("limit", 32'({limitActive, limitSelect}),
          32'({i[2:0] >= 3'h3, i[2:0]}));
      rd(A_BRG, {1'b0, i[3], 3'h0, i[2:0]}, "bridge");
    end
    for (int s = 0; s < 4; s++) begin
      wr(A_SYS, {1'b1, s[1:0], 5'h00});
      wt(2);
      chk("slew", 32'(slewSelect), 32'(s[1:0]));
      chk("enable", 32'(powerStageEnable), 32'h1);
      rd(A_SYS, {1'b1, s[1:0], 5'h00}, "system_control");
    end
    wr(A_SYS, 8'h81);
    wt(2);
    chk("stop", 32'(stopRequest), 32'h1);
    rd(A_SYS, 8'h80, "stop reads");
    cpuIrqReq <= 1'b1;
    wt(10);
    chk("stop cleared", 32'(stopRequest), 32'h0);
    cpuIrqReq <= 1'b0;
    wr(A_OUT, 8'h02);
    wt(3);
    chk("supply only", 32'({lampOutput, switchedSupplyOutput}),
        32'h1);
    wr(A_OUT, 8'h03);
    wt(3);
    chk("lamp", 32'(lampOutput), 32'h1);
    wr(A_SYS, 8'h00);
    wt(3);
    chk("gated", 32'({lampOutput, switchedSupplyOutput}), 32'h0);
    wr(A_SYS, 8'h80);
    wt(3);
    for (int v = 0; v < 2; v++) begin
      {highVoltageDet, lowVoltageDet} <= 2'b01 << v;
      wt(10);
      chk("voltage", 32'({lampOutput, switchedSupplyOutput}),
          32'h1);
      rd(A_STAT, 8'h08 >> v, "status");
      wr(A_IRQ, 8'h01 << v);
      rd(A_IRQ, 8'h01 << v, "flag held");
      {highVoltageDet, lowVoltageDet} <= 2'b00;
      wt(10);
      wr(A_IRQ, 8'h01 << v);
      wt(3);
      rd(A_IRQ, 8'h00, "flag cleared");
      chk("lamp back", 32'(lampOutput), 32'h1);
    end
    {lampOcDet, supplyOcDet} <= 2'b11;
    wt(10);
    {lampOcDet, supplyOcDet} <= 2'b00;
    wt(10);
    chk("tripped", 32'({lampOutput, switchedSupplyOutput}), 32'h0);
    rd(A_STAT, 8'h30, "oc flags");
    chopFrequencyInput <= 1'b1;
    wt(10);
    chk("rearm", 32'({lampOutput, switchedSupplyOutput}), 32'h2);
    chopFrequencyInput <= 1'b0;
    wr(A_STAT, 8'h20);
    wt(3);
    chk("supply back", 32'(switchedSupplyOutput), 32'h1);
    wr(A_STAT, 8'h00);
    rd(A_STAT, 8'h10, "w0 no effect");
    wr(A_STAT, 8'h10);
    rd(A_STAT, 8'h00, "lamp flag clr");
    {hallOcDet, linCurrentLimitDet, bridgeOcDet, overTempWarnDet} <= 4'hF;
    wt(10);
    rd(A_STAT, 8'hC3, "flags");
    rd(A_IRQ, 8'h04, "warn");
    {hallOcDet, linCurrentLimitDet, bridgeOcDet, overTempWarnDet} <= 4'h0;
    wt(10);
    wr(A_STAT, 8'hFF);
    wr(A_IRQ, 8'h04);
    rd(A_STAT, 8'h00, "flags clr");
    overTempLimitDet <= 1'b1;
    wt(10);
    chk("no trip", 32'({systemResetReq, switchedSupplyOutput}),
        32'h1);
    wr(A_IRQ, 8'h80);
    wt(4);
    chk("trip", 32'({systemResetReq, powerStageEnable, lampOutput,
        switchedSupplyOutput}), 32'h8);
    rd(A_IRQ, 8'h80, "ht enable");
    overTempLimitDet <= 1'b0;
    doReset();
    rstCheck();
    apb(1'b0, 8'h3C, 8'h00);
    chk("unmapped", 32'(errSeen), 32'h1);
    chk("unmapped data", rdat, 32'h0);
    apb(1'b1, 8'h0D, 8'hFF);
    chk("misaligned", 32'(errSeen), 32'h1);
    rd(A_SYS, 8'h00, "ignored");
    test_done();
  end
endmodule // tb_top
